/* File: core/fsc_core.sv */
/*
  Control and status flag logic of the on-chip floating-point unit: interface
  flags of control register zero, control word, status word, condition codes,
  stack fault and the routing of numeric errors and device-not-available traps.
  Assumes the integer unit presents one-cycle event pulses synchronous to clk
  and samples trap outputs one cycle after the issuing wait instruction.
*/
`timescale 1ns/1ps

// What this block does
// - Extension-type flag always reads one
// - Report flag selects vector 16 or external
// - Reset clears the numeric-error-report flag
// - Monitor and task-switched raise vector 7 on wait
// - Initialise and reset clear condition codes
// - Incomplete remainder clears codes zero, one, three
// - Incomplete tangent sets condition code two
// - Stack fault sets invalid and fault, loads code one from overflow
// - Infinity control stored but arithmetic stays affine
module fsc_core
  import fsc_pkg::*;
#(
  parameter int NUM_EXC = FSC_NUM_EXC
) (
  input wire logic clk,                  // 20 MHz clock
  input wire logic rstn,                 // Synchronous reset, active low
  input wire logic ifc_write,            // Load interface flags
  input fsc_ifc_t ifc_wdata,             // Flags written by software
  input wire logic cw_write,             // Load control word
  input wire logic [15:0] cw_wdata,      // Control word written by software
  input fsc_event_t events,              // Datapath events
  output fsc_ifc_t control_reg_zero,     // Interface flags as read
  output logic [15:0] control_word,      // Control word as read
  output logic [15:0] status_word,       // Status word as read
  output logic affine_closure,           // Infinity arithmetic mode, always affine
  output logic numeric_error_irq,        // External error interrupt, level
  output fsc_trap_t trap                 // Trap request, one-cycle pulse
);

  if (NUM_EXC != FSC_NUM_EXC) begin : g_bad_num_exc
    $error("NUM_EXC must equal the six exception flags of the status word");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic report;
    logic task_sw;
    logic monitor;
    logic [15:0] cw;
    logic [3:0] cc;
    logic es;
    logic ferr;
    fsc_trap_t trap;
  } fsc_core_state_t;

  fsc_core_state_t state;
  fsc_core_state_t next_state;

  logic [NUM_EXC:0] flag;
  logic [NUM_EXC:0] flag_set;
  logic flag_clr;
  logic pending;
  logic dna_hit;

  // ---------------------------------------------------------------
  // Sticky exception flags and stack fault flag
  // ---------------------------------------------------------------
  always_comb begin
    flag_set = {events.stack_fault, events.exc_raise};
    flag_set[FSC_SW_INVALID_BIT] = events.exc_raise[FSC_SW_INVALID_BIT] | events.stack_fault;
    flag_clr = events.status_clear | events.fpu_initialise_instr;
  end

  for (genvar i = 0; i <= NUM_EXC; i++) begin : g_flag
    fsc_flag_cell #(
      .RESET_VAL(FSC_FLAG_RESET)
    ) i_fsc_flag_cell (
      .clk(clk),
      .rstn(rstn),
      .set(flag_set[i]),
      .clr(flag_clr),
      .flag(flag[i])
    );
  end

  // Unmasked exceptions only
  assign pending = |(flag[NUM_EXC-1:0] & ~state.cw[NUM_EXC-1:0]);
  assign dna_hit = state.monitor & state.task_sw;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.trap = '{dna: 1'h0, numeric: 1'h0, vector: FSC_VEC_NONE};
    if (ifc_write) begin
      next_state.report = ifc_wdata.numeric_error_report_flag;
      next_state.task_sw = ifc_wdata.task_switched_flag;
      next_state.monitor = ifc_wdata.monitor_coprocessor_flag;
    end
    // Infinity control is kept as written and never used
    if (cw_write) begin
      next_state.cw = cw_wdata;
    end
    if (events.cc_load) begin
      next_state.cc = events.cc_value;
    end
    // Code bits held as three, two, one, zero from the top
    if (events.partial_remainder_incomplete) begin
      next_state.cc[0] = 1'h0;
      next_state.cc[1] = 1'h0;
      next_state.cc[3] = 1'h0;
      next_state.cc[2] = 1'h1;
    end
    if (events.partial_tangent_incomplete) begin
      next_state.cc[2] = 1'h1;
    end
    if (events.stack_fault) begin
      next_state.cc[1] = events.stack_overflow;
    end
    if (events.fpu_initialise_instr) begin
      next_state.cc = FSC_CC_RESET;
      next_state.cw = FSC_CW_RESET;
    end
    next_state.es = pending;
    // External route while the report flag is clear
    next_state.ferr = pending & ~state.report;
    if (events.wait_instr) begin
      if (dna_hit) begin
        next_state.trap = '{dna: 1'h1, numeric: 1'h0, vector: FSC_VEC_DNA};
      end else if (pending && state.report) begin
        next_state.trap = '{dna: 1'h0, numeric: 1'h1, vector: FSC_VEC_NUMERIC};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state.report <= FSC_REPORT_RESET;
      state.task_sw <= FSC_TASK_SW_RESET;
      state.monitor <= FSC_MONITOR_RESET;
      state.cw <= FSC_CW_RESET;
      state.cc <= FSC_CC_RESET;
      state.es <= FSC_FLAG_RESET;
      state.ferr <= FSC_FLAG_RESET;
      state.trap <= '{dna: 1'h0, numeric: 1'h0, vector: FSC_VEC_NONE};
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    control_reg_zero.numeric_error_report_flag = state.report;
    control_reg_zero.extension_type_flag = 1'h1;
    control_reg_zero.task_switched_flag = state.task_sw;
    control_reg_zero.monitor_coprocessor_flag = state.monitor;
  end

  assign control_word = state.cw;
  assign status_word = {1'h0, state.cc[3], 3'h0, state.cc[2], state.cc[1], state.cc[0],
                        state.es, flag[NUM_EXC], flag[NUM_EXC-1:0]};
  assign affine_closure = 1'h1;
  assign numeric_error_irq = state.ferr;
  assign trap = state.trap;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_ext_type_one;
    @(posedge clk) disable iff (!rstn) control_reg_zero.extension_type_flag;
  endproperty
  a_ext_type_one: assert property (p_ext_type_one) else $error("extension type not one");

  property p_report_reset;
    @(posedge clk) !rstn |=> !control_reg_zero.numeric_error_report_flag && !numeric_error_irq;
  endproperty
  a_report_reset: assert property (p_report_reset) else $error("report flag not cleared by reset");

  property p_dna;
    @(posedge clk) disable iff (!rstn)
      events.wait_instr && state.monitor && state.task_sw
      |=> trap.dna && !trap.numeric && trap.vector == FSC_VEC_DNA;
  endproperty
  a_dna: assert property (p_dna) else $error("wait did not raise vector 7");

  property p_numeric_int;
    @(posedge clk) disable iff (!rstn)
      events.wait_instr && !(state.monitor && state.task_sw) && pending && state.report
      |=> trap.numeric && trap.vector == FSC_VEC_NUMERIC;
  endproperty
  a_numeric_int: assert property (p_numeric_int) else $error("no vector 16 trap");

  property p_ext_route;
    @(posedge clk) disable iff (!rstn)
      pending && !state.report |=> numeric_error_irq && !trap.numeric;
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("external error not raised");

  property p_masked_silent;
    @(posedge clk) disable iff (!rstn) !pending |=> !numeric_error_irq && !trap.numeric;
  endproperty
  a_masked_silent: assert property (p_masked_silent) else $error("masked exception reported");

  property p_init_cc;
    @(posedge clk) disable iff (!rstn)
      events.fpu_initialise_instr |=> status_word[14] == 1'h0 && status_word[10:8] == 3'h0;
  endproperty
  a_init_cc: assert property (p_init_cc) else $error("initialise left condition codes");

  property p_prem;
    @(posedge clk) disable iff (!rstn)
      events.partial_remainder_incomplete && !events.fpu_initialise_instr && !events.stack_fault
      |=> !status_word[8] && !status_word[9] && !status_word[14];
  endproperty
  a_prem: assert property (p_prem) else $error("remainder left codes set");

  property p_tan;
    @(posedge clk) disable iff (!rstn)
      events.partial_tangent_incomplete && !events.fpu_initialise_instr |=> status_word[10];
  endproperty
  a_tan: assert property (p_tan) else $error("tangent incomplete not flagged");

  property p_stack_fault;
    @(posedge clk) disable iff (!rstn)
      events.stack_fault && !events.fpu_initialise_instr
      |=> status_word[0] && status_word[6] && status_word[9] == $past(events.stack_overflow);
  endproperty
  a_stack_fault: assert property (p_stack_fault) else $error("stack fault flags wrong");

  property p_ic_kept;
    @(posedge clk) disable iff (!rstn)
      cw_write && !events.fpu_initialise_instr
      |=> control_word[12] == $past(cw_wdata[12]) && affine_closure;
  endproperty
  a_ic_kept: assert property (p_ic_kept) else $error("infinity control not kept");

endmodule

/* File: core/fsc_pkg.sv */
/*
  Package for the floating-point control and status flag block: bit positions,
  reset values, trap vectors and the structs that carry control and event bits.
  Assumes a single 20 MHz clock and a synchronous active-low reset.
*/
package fsc_pkg;

  // ---------------------------------------------------------------
  // Control register zero bit positions
  // ---------------------------------------------------------------
  localparam int FSC_CRZ_MONITOR_BIT = 1;
  localparam int FSC_CRZ_EXT_TYPE_BIT = 4;
  localparam int FSC_CRZ_REPORT_BIT = 5;

  // ---------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------
  localparam int FSC_SW_INVALID_BIT = 0;
  localparam int FSC_SW_STACK_FAULT_BIT = 6;
  localparam int FSC_SW_SUMMARY_BIT = 7;
  localparam int FSC_SW_CC0_BIT = 8;
  localparam int FSC_SW_CC1_BIT = 9;
  localparam int FSC_SW_CC2_BIT = 10;
  localparam int FSC_SW_CC3_BIT = 14;

  // ---------------------------------------------------------------
  // Control word fields and values after reset
  // ---------------------------------------------------------------
  localparam int FSC_CW_IC_BIT = 12;
  localparam int FSC_NUM_EXC = 6;
  localparam logic [15:0] FSC_CW_RESET = 16'h037F;
  localparam logic FSC_REPORT_RESET = 1'h0;
  localparam logic FSC_MONITOR_RESET = 1'h0;
  localparam logic FSC_TASK_SW_RESET = 1'h0;
  localparam logic [3:0] FSC_CC_RESET = 4'h0;
  localparam logic FSC_FLAG_RESET = 1'h0;

  // ---------------------------------------------------------------
  // Trap vectors
  // ---------------------------------------------------------------
  localparam logic [7:0] FSC_VEC_DNA = 8'h07;
  localparam logic [7:0] FSC_VEC_NUMERIC = 8'h10;
  localparam logic [7:0] FSC_VEC_NONE = 8'h00;

  // Software view of the interface flags in control register zero
  typedef struct packed {
    logic numeric_error_report_flag;
    logic extension_type_flag;
    logic task_switched_flag;
    logic monitor_coprocessor_flag;
  } fsc_ifc_t;

  // Events from the execution datapath, each a one-cycle pulse
  typedef struct packed {
    logic fpu_initialise_instr;
    logic wait_instr;
    logic partial_remainder_incomplete;
    logic partial_tangent_incomplete;
    logic stack_fault;
    logic stack_overflow;
    logic cc_load;
    logic [3:0] cc_value;
    logic [FSC_NUM_EXC-1:0] exc_raise;
    logic status_clear;
  } fsc_event_t;

  // Trap request towards the integer unit
  typedef struct packed {
    logic dna;
    logic numeric;
    logic [7:0] vector;
  } fsc_trap_t;

endpackage

/* File: core/fsc_flag_cell.sv */
/*
  One sticky status flag: set by hardware, cleared by a clear strobe.
  Assumes the set and clear strobes are synchronous to clk.
*/
`timescale 1ns/1ps
module fsc_flag_cell
  import fsc_pkg::*;
#(
  parameter logic RESET_VAL = FSC_FLAG_RESET
) (
  input wire logic clk,   // 20 MHz clock
  input wire logic rstn,  // Synchronous reset, active low
  input wire logic set,   // Hardware event
  input wire logic clr,   // Clear strobe
  output logic flag       // Sticky flag
);

  typedef struct packed {
    logic flag;
  } fsc_cell_state_t;

  fsc_cell_state_t state;
  fsc_cell_state_t next_state;

  // Set wins over a clear in the same cycle
  always_comb begin
    next_state.flag = set | (state.flag & ~clr);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= '{flag: RESET_VAL};
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;

  property p_set_wins;
    @(posedge clk) disable iff (!rstn) set |=> flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag lost a set");

endmodule

/* File: tb/fsc_iu_model.sv */
/*
  Behavioural model of the integer execution unit: drives control writes and
  one-cycle datapath event pulses into the flag block.
  Assumes one shared clock; every request changes 1 ns after a rising edge.
*/
`timescale 1ns/1ps
module fsc_iu_model
  import fsc_pkg::*;
(
  input wire logic clk,                 // Shared clock
  output logic ifc_write = 1'h0,        // Interface flag write strobe
  output fsc_ifc_t ifc_wdata = 4'h0,    // Interface flags to write
  output logic cw_write = 1'h0,         // Control word write strobe
  output logic [15:0] cw_wdata = 16'h0, // Control word to write
  output fsc_event_t events = '0        // Datapath event pulses
);
  // ---------------------------------------------------------------
  // Requests, each held for exactly one taking edge
  // ---------------------------------------------------------------
  task automatic wr_ifc(input logic report, input logic ext_type, input logic task_sw);
    @(posedge clk);
    #1;
    ifc_write = 1'h1;
    ifc_wdata = {report, ext_type, task_sw, 1'h1}; // Monitor flag kept set
    @(posedge clk);
    #1;
    ifc_write = 1'h0;
  endtask

  task automatic wr_cw(input logic [15:0] d);
    @(posedge clk);
    #1;
    cw_write = 1'h1;
    cw_wdata = d;
    @(posedge clk);
    #1;
    cw_write = 1'h0;
  endtask

  task automatic pulse(input fsc_event_t e);
    @(posedge clk);
    #1;
    events = e;
    @(posedge clk);
    #1;
    events = '0;
  endtask
endmodule

/* File: tb/fpu_status_control_flags_tb.sv */
/*
  Self-checking bench for the flag block: control writes, stack faults,
  condition codes and trap routing, driven through the integer unit model.
  Assumes the design answers at the taking edge, and the summary bit and error line one cycle later.
*/
`timescale 1ns/1ps
module fpu_status_control_flags_tb
  import fsc_pkg::*;
();
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic ifc_write;
  logic cw_write;
  fsc_ifc_t ifc_wdata;
  fsc_ifc_t control_reg_zero;
  logic [15:0] cw_wdata;
  logic [15:0] control_word;
  logic [15:0] status_word;
  fsc_event_t events;
  logic affine_closure;
  logic numeric_error_irq;
  fsc_trap_t trap;
  int errors = 0;
  int num_checks = 0;

  always #25 clk = ~clk;

  fsc_iu_model i_fsc_iu_model (.clk(clk), .ifc_write(ifc_write), .ifc_wdata(ifc_wdata),
    .cw_write(cw_write), .cw_wdata(cw_wdata), .events(events));

  fsc_core i_fsc_core (.clk(clk), .rstn(rstn), .ifc_write(ifc_write), .ifc_wdata(ifc_wdata),
    .cw_write(cw_write), .cw_wdata(cw_wdata), .events(events),
    .control_reg_zero(control_reg_zero), .control_word(control_word),
    .status_word(status_word), .affine_closure(affine_closure),
    .numeric_error_irq(numeric_error_irq), .trap(trap));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] cc();
    return {12'h0, status_word[FSC_SW_CC3_BIT], status_word[FSC_SW_CC2_BIT],
      status_word[FSC_SW_CC1_BIT], status_word[FSC_SW_CC0_BIT]};
  endfunction

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'h1;
    chk({12'h0, control_reg_zero}, 16'h0004);
    chk(control_word, FSC_CW_RESET);
    chk(status_word, 16'h0000);
    chk({15'h0, numeric_error_irq}, 16'h0000);
    chk({15'h0, affine_closure}, 16'h0001);
    $display("test reset done");
    i_fsc_iu_model.wr_ifc(1'h1, 1'h0, 1'h1);
    chk({12'h0, control_reg_zero}, 16'h000F);
    i_fsc_iu_model.pulse(fsc_event_t'{wait_instr:1'h1, default:'0});
    chk({6'h0, trap}, {6'h0, 1'h1, 1'h0, FSC_VEC_DNA});
    tick();
    chk({6'h0, trap}, 16'h0000);
    $display("test device trap done");
    i_fsc_iu_model.wr_ifc(1'h1, 1'h1, 1'h0);
    i_fsc_iu_model.wr_cw(16'h137E);
    chk(control_word, 16'h137E);
    chk({15'h0, affine_closure}, 16'h0001);
    i_fsc_iu_model.pulse(fsc_event_t'{stack_fault:1'h1, stack_overflow:1'h1, default:'0});
    chk(status_word & 16'h0241, 16'h0241);
    i_fsc_iu_model.pulse(fsc_event_t'{wait_instr:1'h1, default:'0});
    chk({6'h0, trap}, {6'h0, 1'h0, 1'h1, FSC_VEC_NUMERIC});
    chk({15'h0, numeric_error_irq}, 16'h0000);
    i_fsc_iu_model.pulse(fsc_event_t'{stack_fault:1'h1, default:'0});
    chk(status_word & 16'h0241, 16'h0041);
    $display("test stack fault done");
    i_fsc_iu_model.wr_ifc(1'h0, 1'h1, 1'h0);
    repeat (2) tick();
    chk({15'h0, numeric_error_irq}, 16'h0001);
    i_fsc_iu_model.pulse(fsc_event_t'{wait_instr:1'h1, default:'0});
    chk({6'h0, trap}, 16'h0000);
    i_fsc_iu_model.wr_cw(FSC_CW_RESET);
    repeat (2) tick();
    chk({15'h0, numeric_error_irq}, 16'h0000);
    i_fsc_iu_model.wr_ifc(1'h1, 1'h1, 1'h0);
    i_fsc_iu_model.pulse(fsc_event_t'{wait_instr:1'h1, default:'0});
    chk({6'h0, trap}, 16'h0000);
    $display("test error route done");
    i_fsc_iu_model.pulse(fsc_event_t'{cc_load:1'h1, cc_value:4'hF, default:'0});
    chk(cc(), 16'h000F);
    i_fsc_iu_model.pulse(fsc_event_t'{partial_remainder_incomplete:1'h1, default:'0});
    chk(cc() & 16'h000B, 16'h0000);
    i_fsc_iu_model.pulse(fsc_event_t'{cc_load:1'h1, default:'0});
    i_fsc_iu_model.pulse(fsc_event_t'{partial_tangent_incomplete:1'h1, default:'0});
    chk(cc() & 16'h0004, 16'h0004);
    i_fsc_iu_model.wr_cw(16'h137E);
    i_fsc_iu_model.pulse(fsc_event_t'{cc_load:1'h1, cc_value:4'hF, default:'0});
    i_fsc_iu_model.pulse(fsc_event_t'{fpu_initialise_instr:1'h1, default:'0});
    chk(cc(), 16'h0000);
    chk(control_word, FSC_CW_RESET);
    $display("test condition codes done");
    // Raise and clear in one cycle: the raise must win
    i_fsc_iu_model.wr_ifc(1'h0, 1'h1, 1'h0);
    i_fsc_iu_model.wr_cw(16'h037B);
    i_fsc_iu_model.pulse(fsc_event_t'{exc_raise:6'h04, status_clear:1'h1, default:'0});
    chk(status_word & 16'h007F, 16'h0004);
    tick();
    chk(status_word & 16'h0080, 16'h0080);
    chk({15'h0, numeric_error_irq}, 16'h0001);
    i_fsc_iu_model.pulse(fsc_event_t'{status_clear:1'h1, default:'0});
    chk(status_word & 16'h007F, 16'h0000);
    i_fsc_iu_model.pulse(fsc_event_t'{exc_raise:6'h08, default:'0});
    tick();
    chk(status_word & 16'h00FF, 16'h0008);
    chk({15'h0, numeric_error_irq}, 16'h0000);
    $display("test exception flags done");
    i_fsc_iu_model.wr_ifc(1'h1, 1'h0, 1'h1);
    i_fsc_iu_model.pulse(fsc_event_t'{cc_load:1'h1, cc_value:4'hF, default:'0});
    chk({12'h0, control_reg_zero}, 16'h000F);
    rstn = 1'h0;
    repeat (2) tick();
    rstn = 1'h1;
    chk({12'h0, control_reg_zero}, 16'h0004);
    chk(status_word, 16'h0000);
    chk(control_word, FSC_CW_RESET);
    chk({15'h0, numeric_error_irq}, 16'h0000);
    i_fsc_iu_model.pulse(fsc_event_t'{wait_instr:1'h1, default:'0});
    chk({6'h0, trap}, 16'h0000);
    $display("test mid reset done");
    summarize();
  end

  // Cuts a hang short well past the expected run of about 70 cycles
  initial begin
    #20000;
    errors++;
    summarize();
  end
endmodule
